/* common/uart_regs_defs.svh */
// offsets, field positions, reset values and codes of the channel registers
`ifndef UART_REGS_DEFS_SVH
`define UART_REGS_DEFS_SVH
// ==========================================================
// register offsets on the three address lines
`define ADR_HOLD     3'h0
`define ADR_DIVHI    3'h1
`define ADR_ISTAT    3'h2
`define ADR_LCTRL    3'h3
`define ADR_MCTRL    3'h4
`define ADR_LSTAT    3'h5
`define ADR_MSTAT    3'h6
`define ADR_SCRATCH  3'h7
// ==========================================================
// keys, field positions and masks
`define ENH_KEY      8'hBF
`define DIV_BIT      7
`define UNLOCK_BIT   4
`define IER_EXT      8'hF0
`define ISR_EXT      8'h30
`define FCR_EXT      8'h30
`define MCR_EXT      8'hE0
`define BYTE_ZERO    8'h00
`define BYTE_ONES    8'hFF
`define REG_RESET    8'h00
// identity codes: arbitrary values
`define REV_CODE     8'h5A
`define DEV_CODE     8'hA5
`endif

/* common/uart_regs_pkg.sv */
// types shared by the dual channel register decode
package uart_regs_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] addr_t;
   // ==========================================================
   // register bank selected by the line control value
   typedef enum logic [1:0] {
      BANK_BASE = 2'b00,
      BANK_DIV  = 2'b01,
      BANK_ENH  = 2'b10
   } bank_t;
   // status coming back from the serial engine
   typedef struct packed {
      byte_t rx_data;
      byte_t line_status;
      byte_t modem_status;
      byte_t int_status;
      byte_t rx_char;
      logic  rx_char_valid;
   } engine_stat_t;
   // configuration driven to the serial engine
   typedef struct packed {
      byte_t divisor_low;
      byte_t divisor_high;
      byte_t int_enable;
      byte_t fifo_control;
      byte_t line_control;
      byte_t modem_control;
      byte_t enhanced_features;
      byte_t resume_char_1;
      byte_t resume_char_2;
      byte_t pause_char_1;
      byte_t pause_char_2;
   } chan_cfg_t;
   // one-cycle events and the held transmit byte for the serial engine
   typedef struct packed {
      logic       tx_load;
      byte_t      tx_data;
      logic       fifo_write;
      logic       rx_pop;
      logic       lsr_read;
      logic       msr_read;
      logic       isr_read;
      logic [3:0] char_match;
   } chan_evt_t;
endpackage

/* hw/dual_uart_register_decode.sv */
// register map and address decode of a two channel uart
`include "uart_regs_defs.svh"

// ==========================================================
// one channel register set
module uart_chan_regs
   import uart_regs_pkg::*;
#(
   parameter byte_t REV = `REV_CODE,
   parameter byte_t DEV = `DEV_CODE
)(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire addr_t        addr_i,
   input  wire byte_t        wdata_i,
   input  wire logic         wr_i,
   input  wire logic         rd_i,
   input  wire engine_stat_t stat_i,
   output byte_t             rdata_o,
   output chan_cfg_t         cfg_o,
   output chan_evt_t         evt_o
);
   byte_t     dll_r;
   byte_t     dlm_r;
   byte_t     ier_r;
   byte_t     fcr_r;
   byte_t     lcr_r;
   byte_t     mcr_r;
   byte_t     efr_r;
   byte_t     xon1_r;
   byte_t     xon2_r;
   byte_t     xoff1_r;
   byte_t     xoff2_r;
   byte_t     spr_r;
   chan_evt_t evt_r;
   chan_evt_t evt_nxt;

   // ==========================================================
   // bank selection from the whole line control value
   wire   key_hit = (lcr_r == `ENH_KEY);
   bank_t bank;
   assign bank = key_hit ? BANK_ENH :
                 lcr_r[`DIV_BIT] ? BANK_DIV : BANK_BASE;
   wire   in_base = (bank == BANK_BASE);
   wire   in_enh  = (bank == BANK_ENH);
   wire   in_div  = (bank == BANK_DIV);
   // identity codes only while the divisor is all zero
   wire   ident = in_div && (dll_r == `BYTE_ZERO)
                  && (dlm_r == `BYTE_ZERO);
   wire   unlock = efr_r[`UNLOCK_BIT];

   // ==========================================================
   // address decode into named strobes
   wire [7:0] hit = 8'h01 << addr_i;
   // divisors stay reachable under the key so a host
   // can leave a zero divisor without losing the bank
   wire wr_thr  = wr_i & hit[0] & in_base;
   wire wr_dll  = wr_i & hit[0] & ~in_base;
   wire wr_dlm  = wr_i & hit[1] & ~in_base;
   wire wr_ier  = wr_i & hit[1] & in_base;
   wire wr_fcr  = wr_i & hit[2] & ~in_enh;
   wire wr_efr  = wr_i & hit[2] & in_enh;
   wire wr_lcr  = wr_i & hit[3];
   wire wr_mcr  = wr_i & hit[4] & ~in_enh;
   wire wr_xon1 = wr_i & hit[4] & in_enh;
   wire wr_xon2 = wr_i & hit[5] & in_enh;
   wire wr_xof1 = wr_i & hit[6] & in_enh;
   wire wr_xof2 = wr_i & hit[7] & in_enh;
   wire wr_spr  = wr_i & hit[7] & ~in_enh;
   // writes at 5 and 6 outside the key hit nothing
   // and leave every register as it was

   // ==========================================================
   // extended bits: set only when unlocked, inert while locked except fcr bits set earlier
   wire [7:0] ier_m = unlock ? `BYTE_ONES : ~`IER_EXT;
   wire [7:0] isr_m = unlock ? `BYTE_ONES : ~`ISR_EXT;
   wire [7:0] fcr_m = unlock ? `BYTE_ONES : ~`FCR_EXT;
   wire [7:0] mcr_m = unlock ? `BYTE_ONES : ~`MCR_EXT;
   wire byte_t ier_w = (wdata_i & ier_m) | (ier_r & ~ier_m);
   wire byte_t mcr_w = (wdata_i & mcr_m) | (mcr_r & ~mcr_m);
   wire byte_t ier_v = ier_r & ier_m;
   wire byte_t mcr_v = mcr_r & mcr_m;
   wire byte_t isr_v = stat_i.int_status & isr_m;

   // ==========================================================
   // read data selection per address
   byte_t rd_word [8];
   assign rd_word[0] = in_base ? stat_i.rx_data :
                       ident ? REV : dll_r;
   assign rd_word[1] = in_base ? ier_v :
                       ident ? DEV : dlm_r;
   assign rd_word[2] = in_enh ? efr_r : isr_v;
   assign rd_word[3] = lcr_r;
   assign rd_word[4] = in_enh ? xon1_r : mcr_v;
   assign rd_word[5] = in_enh ? xon2_r :
                       stat_i.line_status;
   assign rd_word[6] = in_enh ? xoff1_r :
                       stat_i.modem_status;
   assign rd_word[7] = in_enh ? xoff2_r : spr_r;
   assign rdata_o = rd_word[addr_i];

   // ==========================================================
   // character compare masked to the programmed word length
   wire [7:0] wl_mask = `BYTE_ONES >> (2'd3 - lcr_r[1:0]);
   wire byte_t rc = stat_i.rx_char;
   wire [3:0] cmp;
   assign cmp[0] = ((rc ^ xon1_r) & wl_mask) == 8'h00;
   assign cmp[1] = ((rc ^ xon2_r) & wl_mask) == 8'h00;
   assign cmp[2] = ((rc ^ xoff1_r) & wl_mask) == 8'h00;
   assign cmp[3] = ((rc ^ xoff2_r) & wl_mask) == 8'h00;

   // ==========================================================
   // next event word: pulses last one cycle, tx data holds
   always_comb begin
      evt_nxt            = '0;
      evt_nxt.tx_data    = wr_thr ? wdata_i : evt_r.tx_data;
      evt_nxt.tx_load    = wr_thr;
      evt_nxt.fifo_write = wr_fcr;
      evt_nxt.rx_pop     = rd_i & hit[0] & in_base;
      evt_nxt.isr_read   = rd_i & hit[2] & ~in_enh;
      evt_nxt.lsr_read   = rd_i & hit[5] & ~in_enh;
      evt_nxt.msr_read   = rd_i & hit[6] & ~in_enh;
      evt_nxt.char_match = stat_i.rx_char_valid ? cmp : 4'h0;
   end

   // ==========================================================
   // storage; all registers clear on reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         dll_r   <= `REG_RESET;
         dlm_r   <= `REG_RESET;
         ier_r   <= `REG_RESET;
         fcr_r   <= `REG_RESET;
         lcr_r   <= `REG_RESET;
         mcr_r   <= `REG_RESET;
         efr_r   <= `REG_RESET;
         xon1_r  <= `REG_RESET;
         xon2_r  <= `REG_RESET;
         xoff1_r <= `REG_RESET;
         xoff2_r <= `REG_RESET;
         spr_r   <= `REG_RESET;
         evt_r   <= '0;
      end else begin
         if (wr_dll)  dll_r   <= wdata_i;
         if (wr_dlm)  dlm_r   <= wdata_i;
         if (wr_ier)  ier_r   <= ier_w;
         if (wr_fcr)  fcr_r   <= wdata_i & fcr_m;
         if (wr_lcr)  lcr_r   <= wdata_i;
         if (wr_mcr)  mcr_r   <= mcr_w;
         if (wr_efr)  efr_r   <= wdata_i;
         if (wr_xon1) xon1_r  <= wdata_i;
         if (wr_xon2) xon2_r  <= wdata_i;
         if (wr_xof1) xoff1_r <= wdata_i;
         if (wr_xof2) xoff2_r <= wdata_i;
         if (wr_spr)  spr_r   <= wdata_i;
         evt_r <= evt_nxt;
      end
   end

   // effective values: locked extended bits read as zero except in fifo control
   assign cfg_o = '{divisor_low: dll_r, divisor_high: dlm_r,
                    int_enable: ier_v, fifo_control: fcr_r,
                    line_control: lcr_r, modem_control: mcr_v,
                    enhanced_features: efr_r,
                    resume_char_1: xon1_r, resume_char_2: xon2_r,
                    pause_char_1: xoff1_r, pause_char_2: xoff2_r};
   assign evt_o = evt_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_lcr_any_bank: assert property (
      wr_i && addr_i == `ADR_LCTRL |=> lcr_r == $past(wdata_i))
      else $error("line control write lost");
   a_tx_load_base: assert property (
      wr_i && addr_i == `ADR_HOLD && in_base
      |=> evt_o.tx_load && evt_o.tx_data == $past(wdata_i))
      else $error("transmit load missing");
   a_div_write: assert property (
      wr_i && addr_i == `ADR_HOLD && in_div
      |=> dll_r == $past(wdata_i) && !evt_o.tx_load)
      else $error("divisor low write wrong");
   a_ident_codes: assert property (
      ident && addr_i == `ADR_HOLD |-> rdata_o == REV)
      else $error("revision code not shown");
   a_ier_low_bits: assert property (
      wr_i && addr_i == `ADR_DIVHI && in_base
      |=> ier_r[3:0] == $past(wdata_i[3:0]))
      else $error("interrupt enable write lost");
   a_isr_view: assert property (
      !in_enh && addr_i == `ADR_ISTAT
      |-> rdata_o[3:0] == stat_i.int_status[3:0])
      else $error("status read wrong");
   a_efr_swap: assert property (
      wr_i && addr_i == `ADR_ISTAT && in_enh
      |=> efr_r == $past(wdata_i) && !evt_o.fifo_write)
      else $error("enhanced write went to fifo");
   a_ext_locked: assert property (
      !unlock |-> (cfg_o.int_enable & `IER_EXT) == 8'h00
      && (cfg_o.modem_control & `MCR_EXT) == 8'h00)
      else $error("extended bits active while locked");
   a_rsvd_write: assert property (
      wr_i && !in_enh && addr_i == `ADR_LSTAT
      |=> $stable(cfg_o))
      else $error("reserved write changed state");
   a_scratch_keep: assert property (
      wr_i && !in_enh && addr_i == `ADR_SCRATCH
      ##1 (!wr_i) [*2] |-> spr_r == $past(wdata_i, 2))
      else $error("scratch lost its value");
   a_short_match: assert property (
      stat_i.rx_char_valid && lcr_r[1:0] == 2'b00
      && rc[4:0] == xoff1_r[4:0] |=> evt_o.char_match[2])
      else $error("five bit compare missed");
   a_ier_reset: assert property (
      $rose(rst_n_i) |-> ier_r[0] == 1'b0)
      else $error("receive interrupt enabled at reset");

   c_ident_read: cover property (ident && rd_i);
   c_enh_write:  cover property (wr_efr);
   c_tx_load:    cover property (wr_thr);
   c_pause_hit:  cover property (evt_o.char_match[3]);
endmodule

// ==========================================================
// bus front end shared by the two channels
module dual_uart_register_decode
   import uart_regs_pkg::*;
#(
   parameter byte_t REV_CODE = `REV_CODE,  // arbitrary value
   parameter byte_t DEV_CODE = `DEV_CODE   // arbitrary value
)(
   input  wire logic         MCLK_I,
   input  wire logic         RESETN_I,
   input  wire addr_t        ADDR_I,
   input  wire logic         CHANNEL_A_SELECT_N_I,
   input  wire logic         CHANNEL_B_SELECT_N_I,
   input  wire logic         READ_N_I,
   input  wire logic         WRITE_N_I,
   input  wire byte_t        DATA_I,
   output byte_t             DATA_O,
   output logic              DATA_OE_O,
   input  wire engine_stat_t STAT_A_I,
   input  wire engine_stat_t STAT_B_I,
   output chan_cfg_t         CFG_A_O,
   output chan_cfg_t         CFG_B_O,
   output chan_evt_t         EVT_A_O,
   output chan_evt_t         EVT_B_O
);
   logic  rd_n_q_r;
   logic  wr_n_q_r;
   byte_t data_r;
   logic  oe_r;
   byte_t rdata_a;
   byte_t rdata_b;

   // ==========================================================
   // channel choice; both selects low selects nothing
   wire sel_a = !CHANNEL_A_SELECT_N_I
                && CHANNEL_B_SELECT_N_I;
   wire sel_b = !CHANNEL_B_SELECT_N_I
                && CHANNEL_A_SELECT_N_I;
   wire sel_any = sel_a | sel_b;
   // a held strobe reaches the channels once, on its first low cycle
   wire wr_take = !WRITE_N_I && wr_n_q_r;
   wire rd_take = !READ_N_I && rd_n_q_r;
   wire rd_act  = !READ_N_I && sel_any;

   // ==========================================================
   // strobe history and registered read data
   always_ff @(posedge MCLK_I) begin
      if (!RESETN_I) begin
         rd_n_q_r <= 1'b1;
         wr_n_q_r <= 1'b1;
         data_r   <= `BYTE_ZERO;
         oe_r     <= 1'b0;
      end else begin
         rd_n_q_r <= READ_N_I;
         wr_n_q_r <= WRITE_N_I;
         oe_r     <= rd_act;
         if (rd_act) data_r <= sel_a ? rdata_a : rdata_b;
      end
   end
   assign DATA_O    = data_r;
   assign DATA_OE_O = oe_r;

   // ==========================================================
   // the two channel register sets
   uart_chan_regs #(.REV(REV_CODE), .DEV(DEV_CODE)) u_chan_a (
      .clk_i   (MCLK_I),
      .rst_n_i (RESETN_I),
      .addr_i  (ADDR_I),
      .wdata_i (DATA_I),
      .wr_i    (wr_take & sel_a),
      .rd_i    (rd_take & sel_a),
      .stat_i  (STAT_A_I),
      .rdata_o (rdata_a),
      .cfg_o   (CFG_A_O),
      .evt_o   (EVT_A_O)
   );
   uart_chan_regs #(.REV(REV_CODE), .DEV(DEV_CODE)) u_chan_b (
      .clk_i   (MCLK_I),
      .rst_n_i (RESETN_I),
      .addr_i  (ADDR_I),
      .wdata_i (DATA_I),
      .wr_i    (wr_take & sel_b),
      .rd_i    (rd_take & sel_b),
      .stat_i  (STAT_B_I),
      .rdata_o (rdata_b),
      .cfg_o   (CFG_B_O),
      .evt_o   (EVT_B_O)
   );
endmodule

/* testbench/host_bus_model.sv */
// host processor model driving the parallel register port
module host_bus_model
   import uart_regs_pkg::*;
(
   input  wire logic  clk_i,
   input  wire byte_t data_i,
   input  wire logic  data_oe_i,
   output addr_t      addr_o,
   output logic       sel_a_n_o,
   output logic       sel_b_n_o,
   output logic       rd_n_o,
   output logic       wr_n_o,
   output byte_t      data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // idle bus: strobes and selects high, data not left at old value
   initial begin
      addr_o = 3'h0;
      sel_a_n_o = 1'b1;
      sel_b_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      data_o = 8'h00;
   end
   // channel 2 drops both selects: an illegal access the device ignores
   task automatic start(input int ch, input addr_t a);
      addr_o <= a;
      sel_a_n_o <= (ch == 1);
      sel_b_n_o <= (ch == 0);
   endtask
   // one write; strobe then stays high an edge so the next is seen
   task automatic wr(input int ch, input addr_t a, input byte_t d);
      @(posedge clk_i);
      start(ch, a);
      data_o <= d;
      wr_n_o <= 1'b0;
      @(posedge clk_i);
      wr_n_o <= 1'b1;
      sel_a_n_o <= 1'b1;
      sel_b_n_o <= 1'b1;
      data_o <= ~d;
   endtask
   // one read; data is registered at the taking edge, taken just after
   task automatic rd(input int ch, input addr_t a, output byte_t q,
                     output logic oe);
      @(posedge clk_i);
      start(ch, a);
      rd_n_o <= 1'b0;
      @(posedge clk_i);
      rd_n_o <= 1'b1;
      sel_a_n_o <= 1'b1;
      sel_b_n_o <= 1'b1;
      #1;
      q = data_i;
      oe = data_oe_i;
   endtask
endmodule

/* testbench/tb_dual_uart_register_decode.sv */
// self-checking bench for the dual channel register decode
module tb_dual_uart_register_decode
   import uart_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam byte_t REV = 8'h3C; // arbitrary value
   localparam byte_t DEV = 8'hC3; // arbitrary value
   logic         mclk;
   logic         resetn;
   addr_t        addr;
   logic         sel_a_n, sel_b_n, rd_n, wr_n;
   byte_t        wdata, rdata;
   logic         oe;
   engine_stat_t st[2];
   chan_cfg_t    cfg[2];
   chan_evt_t    evt[2];
   int           err_count, n_checks, cycles;
   int           lc[2], dl[2], dh[2], ie[2], mc[2], ef[2], sp[2];
   int           xc[2][4];
   // ==========================================================
   // device and host
   dual_uart_register_decode #(.REV_CODE(REV), .DEV_CODE(DEV))
   dual_uart_register_decode_i (
      .MCLK_I(mclk), .RESETN_I(resetn), .ADDR_I(addr),
      .CHANNEL_A_SELECT_N_I(sel_a_n), .CHANNEL_B_SELECT_N_I(sel_b_n),
      .READ_N_I(rd_n), .WRITE_N_I(wr_n), .DATA_I(wdata),
      .DATA_O(rdata), .DATA_OE_O(oe), .STAT_A_I(st[0]),
      .STAT_B_I(st[1]), .CFG_A_O(cfg[0]), .CFG_B_O(cfg[1]),
      .EVT_A_O(evt[0]), .EVT_B_O(evt[1]));
   host_bus_model host_bus_model_i (
      .clk_i(mclk), .data_i(rdata), .data_oe_i(oe), .addr_o(addr),
      .sel_a_n_o(sel_a_n), .sel_b_n_o(sel_b_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .data_o(wdata));
   // ==========================================================
   // clock and hang guard: ~3 cycles per access, ceiling well above
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // ==========================================================
   // reference model: bank 0 base, 1 divisor, 2 enhanced
   function automatic int bank(int c);
      return (lc[c] == 8'hBF) ? 2 : (lc[c] >> 7) & 1;
   endfunction
   function automatic int locked(int c);
      return ((ef[c] >> 4) & 1) == 0;
   endfunction
   function automatic int exp_rd(int c, int a);
      int bk;
      int lk;
      int id;
      bk = bank(c);
      lk = locked(c);
      id = (bk == 1) && (dl[c] == 0) && (dh[c] == 0);
      case (a)
         0: return bk == 0 ? st[c].rx_data : id ? REV : dl[c];
         1: return bk == 0 ? (lk ? ie[c] & 'h0F : ie[c]) : id ? DEV : dh[c];
         2: return bk == 2 ? ef[c] :
                   (lk ? st[c].int_status & 'hCF : st[c].int_status);
         3: return lc[c];
         4: return bk == 2 ? xc[c][0] : (lk ? mc[c] & 'h1F : mc[c]);
         5: return bk == 2 ? xc[c][1] : st[c].line_status;
         6: return bk == 2 ? xc[c][2] : st[c].modem_status;
         default: return bk == 2 ? xc[c][3] : sp[c];
      endcase
   endfunction
   // flow characters compare only the programmed word length bits
   function automatic logic [3:0] exp_match(int c);
      int         m;
      logic [3:0] r;
      m = 'hFF >> (3 - (lc[c] & 3));
      for (int k = 0; k < 4; k++)
         r[k] = ((st[c].rx_char ^ xc[c][k]) & m) == 0;
      return st[c].rx_char_valid ? r : 4'h0;
   endfunction
   // locked upper bits keep what they held; reserved writes drop
   task automatic mwr(int c, int a, int d, int bk, int lk);
      case (a)
         0: if (bk != 0) dl[c] = d;
         1: if (bk != 0) dh[c] = d;
            else ie[c] = lk ? (ie[c] & 'hF0) | (d & 'h0F) : d;
         2: if (bk == 2) ef[c] = d;
         3: lc[c] = d;
         4: if (bk == 2) xc[c][0] = d;
            else mc[c] = lk ? (mc[c] & 'hE0) | (d & 'h1F) : d;
         7: if (bk == 2) xc[c][3] = d;
            else sp[c] = d;
         default: if (bk == 2) xc[c][a - 4] = d;
      endcase
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         {lc[c], dl[c], dh[c], ie[c], mc[c], ef[c], sp[c]} = '0;
         xc[c] = '{0, 0, 0, 0};
      end
   endtask
   // ==========================================================
   // random accesses of both channels, with a reset part way
   initial begin
      int    c, a, d, bk, lk, r;
      byte_t q;
      logic  qoe;
      byte_t last;
      logic [63:0] rnd;
      err_count = 0;
      n_checks = 0;
      cycles = 0;
      resetn = 1'b0;
      st[0] = '0;
      st[1] = '0;
      last = 8'h00;
      void'($urandom(32'he45f_d729));
      do_reset();
      for (int i = 0; i < 4000; i++) begin
         if (i == 2000) begin
            do_reset();
            last = 8'h00;
         end
         @(posedge mclk);
         rnd = {$urandom, $urandom};
         st[0] <= engine_stat_t'(rnd[40:0]);
         rnd = {$urandom, $urandom};
         st[1] <= engine_stat_t'(rnd[40:0]);
         r = $urandom_range(15, 0);
         c = (r == 0) ? 2 : r & 1;
         a = (i < 8) ? 1 : $urandom_range(7, 0);
         d = $urandom_range(255, 0);
         if (a == 3 && r < 12)
            d = (r < 4) ? 8'h00 : (r < 8) ? 8'h80 : 8'hBF;
         if (a < 2 && r > 9)
            d = 0;
         if (i < 8 || $urandom_range(1, 0)) begin
            host_bus_model_i.rd(c, addr_t'(a), q, qoe);
            if (c == 2) begin
               chk(qoe, 1'b0);
               chk(q, last);
            end else begin
               chk(qoe, 1'b1);
               chk(q, byte_t'(exp_rd(c, a)));
               bk = bank(c);
               chk(evt[c].rx_pop, a == 0 && bk == 0);
               chk(evt[c].isr_read, a == 2 && bk != 2);
               chk(evt[c].lsr_read, a == 5 && bk != 2);
               chk(evt[c].msr_read, a == 6 && bk != 2);
               chk(evt[c].char_match, exp_match(c));
               chk(cfg[c].divisor_low, byte_t'(dl[c]));
               last = q;
            end
         end else begin
            bk = (c < 2) ? bank(c) : 0;
            lk = (c < 2) ? locked(c) : 1;
            host_bus_model_i.wr(c, addr_t'(a), byte_t'(d));
            #1;
            if (c < 2) begin
               mwr(c, a, d, bk, lk);
               chk(evt[c].tx_load, a == 0 && bk == 0);
               if (a == 0 && bk == 0)
                  chk(evt[c].tx_data, byte_t'(d));
               chk(evt[c].fifo_write, a == 2 && bk != 2);
               if (a == 2 && bk != 2)
                  chk(cfg[c].fifo_control, byte_t'(lk ? d & 'hCF : d));
            end else begin
               chk(evt[0].tx_load | evt[1].tx_load, 1'b0);
            end
         end
      end
      finish_test();
   end
endmodule
